// ==== uidfc_top.v ====
// serial port interrupt flags, dma request lines and hardware flow
// control, with the receive and transmit fifos in the data path
// assumes shift logic and baud generation outside, on the same clk
// assumes receive strobes and dma clear pulses last one clk cycle
// assumes clear-to-send and infrared input are async pins, idle high
// assumes the shifter pulses txLoad only while txStartOk_ff is high
//
// Function
// - break, parity, framing flags set by events, cleared by clear write
// - overrun flag follows overrun, cleared when receive fifo is read
// - interrupt output is the or of all masked status bits
// - overrun raised at last stop bit when receive fifo full
// - break and receive interrupts at last stop bit, second if two
// - parity error raised once parity bit received
// - framing error raised at bit where frame is violated
// - timeout after 511 x16 ticks with data waiting in fifo
// - transmit interrupt after msb of last queued character sent
// - receive single dma request while receive fifo not empty
// - receive burst dma request while level above watermark
// - receive clear pulse from dma drops receive requests
// - transmit single dma request while any free location exists
// - transmit burst dma request while level below watermark
// - transmit clear pulse from dma drops transmit requests
// - receive single and burst together above watermark, single only below
// - infrared encoder output has inverse polarity of decoder input
// - with rx flow control, rts active until level passes watermark
// - rts active again once reads bring level back down
// - with tx flow control, cts checked before each character
// - cts lost mid character: character finishes, then stop
// - separate enables for tx and rx flow control, 1 enables
// - interrupt clear is write only, 1 clears, 0 no effect
// - dma stop on error suppresses both receive dma requests
// - transmit fifo 8 x 32, one byte holding register if disabled
`timescale 1ns/100ps
`default_nettype none
`include "uidfc_map.vh"

// -----------------------------------------------------------------
// fifo with registered flags and count
// -----------------------------------------------------------------
module uidfc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire nrst,
  input wire oneDeep,
  input wire inValid,
  output reg inReady,
  input wire [WIDTH-1:0] inData,
  output reg outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData,
  output reg [AW:0] count
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_ff;
  reg [AW-1:0] rdPtr_ff;
  reg [AW:0] nxt_count;
  reg [AW:0] limit;
  wire doPush;
  wire doPop;

  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;
  assign outData = mem[rdPtr_ff];

  always @* begin
    limit = oneDeep ? {{AW{1'b0}}, 1'b1} : DEPTH[AW:0];
    nxt_count = count;
    if (doPush && !doPop) begin
      nxt_count = count + {{AW{1'b0}}, 1'b1};
    end else if (doPop && !doPush) begin
      nxt_count = count - {{AW{1'b0}}, 1'b1};
    end
  end

  always @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      inReady <= 1'b0;
      outValid <= 1'b0;
    end else begin
      if (doPush) begin
        wrPtr_ff <= wrPtr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doPop) begin
        rdPtr_ff <= rdPtr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      count <= nxt_count;
      inReady <= (nxt_count < limit);
      outValid <= (nxt_count != {(AW+1){1'b0}});
    end
  end
endmodule

// -----------------------------------------------------------------
// pin synchroniser: three flops, a change counts once two agree
// -----------------------------------------------------------------
module uidfc_sync3 #(
  parameter [0:0] IDLE = 1'b1
) (
  input wire clk,
  input wire nrst,
  input wire pinIn,
  output reg level_ff
);
  reg [2:0] sync_ff;

  // preset to the idle level so reset release gives no false edge
  always @(posedge clk) begin
    if (!nrst) begin
      sync_ff <= {3{IDLE}};
      level_ff <= IDLE;
    end else begin
      sync_ff <= {sync_ff[1:0], pinIn};
      if (sync_ff[1] == sync_ff[2]) begin
        level_ff <= sync_ff[2];
      end
    end
  end
endmodule

// -----------------------------------------------------------------
// top: flags, dma requests, flow control
// -----------------------------------------------------------------
module uidfc_top (
  input wire clk,
  input wire nrst,
  input wire fifoEnable,
  input wire twoStopBitsSel,
  input wire oversampleTickX16,
  input wire stopBitStrobe,
  input wire stopBitIsSecond,
  input wire [7:0] rxCharData,
  input wire rxBreakBit,
  input wire rxParityBit,
  input wire rxFrameBit,
  input wire parityErrStrobe,
  input wire frameErrStrobe,
  input wire rxReadReq,
  output reg rxReadValid_ff,
  output reg [11:0] rxReadData_ff,
  output wire rxFifoNotEmpty,
  input wire txWrValid,
  input wire [7:0] txWrData,
  output wire txWrReady,
  input wire txLoad,
  input wire txMsbDone,
  output reg txStartOk_ff,
  output reg [7:0] txChar_ff,
  input wire [6:0] irqMask,
  input wire irqClearWr,
  input wire [6:0] irqClearData,
  output reg [6:0] rawStatus_ff,
  output reg [6:0] maskedStatus_ff,
  output reg serialPortIrq_ff,
  input wire rxDmaEn,
  input wire txDmaEn,
  input wire dmaStopOnRxError,
  input wire [2:0] rxWatermarkSel,
  input wire [2:0] txWatermarkSel,
  input wire rxDmaReqClear,
  input wire txDmaReqClear,
  output reg rxDmaSingleReq_ff,
  output reg rxDmaBurstReq_ff,
  output reg txDmaSingleReq_ff,
  output reg txDmaBurstReq_ff,
  input wire txFlowCtrlEn,
  input wire rxFlowCtrlEn,
  input wire clearToSend_n,
  output reg requestToSend_n_ff,
  input wire irEncodePulse,
  input wire infraredRxIn_n,
  output reg infraredTxOut_ff,
  output reg irRxPulse_ff
);
  wire rxInReady;
  wire rxOutValid;
  wire [11:0] rxOutData;
  wire [2:0] rxCount;
  wire txOutValid;
  wire [7:0] txOutData;
  wire [5:0] txCount;
  wire lastStop;
  wire rxPop;
  wire txPop;
  wire [5:0] txLevel;
  wire ctsPin_n;
  wire irPin_n;
  reg [8:0] rtCount_ff;
  reg [6:0] nxt_raw;
  reg [6:0] setEv;
  reg [6:0] clrEv;
  reg nxt_rtHit;
  reg [8:0] nxt_rtCount;
  wire rxSuppress;
  wire ctsOk;

  // -----------------------------------------------------------------
  // fifos
  // -----------------------------------------------------------------
  assign lastStop = stopBitStrobe && (!twoStopBitsSel || stopBitIsSecond);
  assign rxPop = rxReadReq && rxOutValid;
  assign rxFifoNotEmpty = rxOutValid;

  uidfc_fifo #(
    .WIDTH(`UIDFC_RX_WIDTH),
    .DEPTH(`UIDFC_RX_DEPTH),
    .AW(`UIDFC_RX_AW)
  ) rxFifo (
    .clk(clk),
    .nrst(nrst),
    .oneDeep(!fifoEnable),
    .inValid(lastStop),
    .inReady(rxInReady),
    .inData({1'b0, rxBreakBit, rxParityBit, rxFrameBit, rxCharData}),
    .outValid(rxOutValid),
    .outReady(rxReadReq),
    .outData(rxOutData),
    .count(rxCount)
  );

  // one byte holding register when the fifo is off
  uidfc_fifo #(
    .WIDTH(`UIDFC_TX_WIDTH),
    .DEPTH(`UIDFC_TX_DEPTH),
    .AW(`UIDFC_TX_AW)
  ) txFifo (
    .clk(clk),
    .nrst(nrst),
    .oneDeep(!fifoEnable),
    .inValid(txWrValid),
    .inReady(txWrReady),
    .inData(txWrData),
    .outValid(txOutValid),
    .outReady(txPop),
    .outData(txOutData),
    .count(txCount)
  );

  // shifter takes a character only while start is allowed
  assign txPop = txLoad && txStartOk_ff && txOutValid;

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  uidfc_sync3 #(
    .IDLE(1'b1)
  ) ctsSync (
    .clk(clk),
    .nrst(nrst),
    .pinIn(clearToSend_n),
    .level_ff(ctsPin_n)
  );

  uidfc_sync3 #(
    .IDLE(1'b1)
  ) irSync (
    .clk(clk),
    .nrst(nrst),
    .pinIn(infraredRxIn_n),
    .level_ff(irPin_n)
  );

  // -----------------------------------------------------------------
  // interrupt flags
  // -----------------------------------------------------------------
  always @* begin
    nxt_rtCount = rtCount_ff;
    nxt_rtHit = 1'b0;
    if (!rxOutValid || lastStop || rxPop) begin
      nxt_rtCount = 9'h000;
    end else if (oversampleTickX16) begin
      if (rtCount_ff == `UIDFC_RT_TICKS - 9'h001) begin
        nxt_rtHit = 1'b1;
      end
      if (rtCount_ff != `UIDFC_RT_TICKS) begin
        nxt_rtCount = rtCount_ff + 9'h001;
      end
    end
  end

  always @* begin
    setEv = 7'h00;
    setEv[`UIDFC_BIT_RX] = lastStop;
    setEv[`UIDFC_BIT_TX] = txMsbDone && !txOutValid;
    setEv[`UIDFC_BIT_RT] = nxt_rtHit;
    setEv[`UIDFC_BIT_FE] = frameErrStrobe;
    setEv[`UIDFC_BIT_PE] = parityErrStrobe;
    setEv[`UIDFC_BIT_BE] = lastStop && rxBreakBit;
    setEv[`UIDFC_BIT_OE] = lastStop && !rxInReady;
    clrEv = irqClearWr ? irqClearData : 7'h00;
    clrEv[`UIDFC_BIT_OE] = clrEv[`UIDFC_BIT_OE] || rxPop;
    nxt_raw = (rawStatus_ff & ~clrEv) | setEv;
  end

  always @(posedge clk) begin
    if (!nrst) begin
      rtCount_ff <= 9'h000;
      rawStatus_ff <= `UIDFC_IRQ_RST;
      maskedStatus_ff <= `UIDFC_IRQ_RST;
      serialPortIrq_ff <= 1'b0;
    end else begin
      rtCount_ff <= nxt_rtCount;
      rawStatus_ff <= nxt_raw;
      maskedStatus_ff <= nxt_raw & irqMask;
      serialPortIrq_ff <= |(nxt_raw & irqMask);
    end
  end

  // -----------------------------------------------------------------
  // dma requests
  // -----------------------------------------------------------------
  assign rxSuppress = dmaStopOnRxError && (|nxt_raw[`UIDFC_BIT_OE:`UIDFC_BIT_FE]);
  assign txLevel = {1'b0, txWatermarkSel, 2'b00} + `UIDFC_TX_LVL_STEP;

  always @(posedge clk) begin
    if (!nrst) begin
      rxDmaSingleReq_ff <= 1'b0;
      rxDmaBurstReq_ff <= 1'b0;
      txDmaSingleReq_ff <= 1'b0;
      txDmaBurstReq_ff <= 1'b0;
    end else begin
      rxDmaSingleReq_ff <= rxDmaEn && !rxSuppress && !rxDmaReqClear
        && rxOutValid;
      rxDmaBurstReq_ff <= rxDmaEn && !rxSuppress && !rxDmaReqClear
        && ({3'h0, rxCount} > {3'h0, rxWatermarkSel});
      txDmaSingleReq_ff <= txDmaEn && !txDmaReqClear && txWrReady;
      txDmaBurstReq_ff <= txDmaEn && !txDmaReqClear && txWrReady
        && (txCount < txLevel);
    end
  end

  // -----------------------------------------------------------------
  // flow control, transmit hand-off, infrared polarity
  // -----------------------------------------------------------------
  assign ctsOk = !txFlowCtrlEn || !ctsPin_n;

  always @(posedge clk) begin
    if (!nrst) begin
      requestToSend_n_ff <= 1'b1;
      txStartOk_ff <= 1'b0;
      txChar_ff <= 8'h00;
      rxReadValid_ff <= 1'b0;
      rxReadData_ff <= 12'h000;
      infraredTxOut_ff <= 1'b0;
      irRxPulse_ff <= 1'b0;
    end else begin
      // active low; drops above watermark, back once level is at or below it
      requestToSend_n_ff <= rxFlowCtrlEn
        && ({3'h0, rxCount} > {3'h0, rxWatermarkSel});
      // gates only character starts, a running one completes
      txStartOk_ff <= txOutValid && ctsOk && !txPop;
      txChar_ff <= txOutData;
      rxReadValid_ff <= rxPop;
      if (rxPop) begin
        rxReadData_ff <= {rawStatus_ff[`UIDFC_BIT_OE], rxOutData[10:0]};
      end
      infraredTxOut_ff <= irEncodePulse;
      irRxPulse_ff <= !irPin_n;
    end
  end
endmodule
`default_nettype wire

// ==== uidfc_map.vh ====
// constants for the serial port interrupt, dma and flow control block
// assumes inclusion by bare name from the design file
`ifndef UIDFC_MAP_VH
`define UIDFC_MAP_VH
// -----------------------------------------------------------------
// interrupt status bit positions (7-bit vectors)
// -----------------------------------------------------------------
`define UIDFC_IRQ_W 7
`define UIDFC_BIT_RX 0
`define UIDFC_BIT_TX 1
`define UIDFC_BIT_RT 2
`define UIDFC_BIT_FE 3
`define UIDFC_BIT_PE 4
`define UIDFC_BIT_BE 5
`define UIDFC_BIT_OE 6
`define UIDFC_IRQ_RST 7'h00
// -----------------------------------------------------------------
// fifo shapes
// -----------------------------------------------------------------
`define UIDFC_RX_WIDTH 12
`define UIDFC_RX_DEPTH 4
`define UIDFC_RX_AW 2
`define UIDFC_TX_WIDTH 8
`define UIDFC_TX_DEPTH 32
`define UIDFC_TX_AW 5
// rx fifo word fields
`define UIDFC_RXW_FE 8
`define UIDFC_RXW_PE 9
`define UIDFC_RXW_BE 10
`define UIDFC_RXW_OE 11
// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define UIDFC_RT_TICKS 9'h1FF
`define UIDFC_TX_LVL_STEP 6'h04
`endif

// ==== uidfc_top_sva.sv ====
// assertion checker for the serial port irq, dma and flow control top
// assumes a bind onto uidfc_top from the testbench top file
`timescale 1ns/100ps
`default_nettype none
module uidfc_top_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic twoStopBitsSel,
  input wire logic stopBitStrobe,
  input wire logic stopBitIsSecond,
  input wire logic parityErrStrobe,
  input wire logic frameErrStrobe,
  input wire logic [6:0] irqMask,
  input wire logic irqClearWr,
  input wire logic [6:0] irqClearData,
  input wire logic [6:0] rawStatus_ff,
  input wire logic [6:0] maskedStatus_ff,
  input wire logic serialPortIrq_ff,
  input wire logic dmaStopOnRxError,
  input wire logic rxDmaReqClear,
  input wire logic txDmaReqClear,
  input wire logic rxDmaSingleReq_ff,
  input wire logic rxDmaBurstReq_ff,
  input wire logic txDmaSingleReq_ff,
  input wire logic txDmaBurstReq_ff,
  input wire logic rxFlowCtrlEn,
  input wire logic requestToSend_n_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  AST_IRQ_OR: assert property (serialPortIrq_ff == (|maskedStatus_ff))
    else $error("irq output differs from or of masked status");
  AST_MASKED: assert property (maskedStatus_ff == (rawStatus_ff & $past(irqMask)))
    else $error("masked status differs from raw and mask");
  AST_RX_LAST_STOP: assert property (stopBitStrobe && (!twoStopBitsSel || stopBitIsSecond)
    |=> rawStatus_ff[0])
    else $error("receive flag not set at last stop bit");
  AST_PARITY_SET: assert property (parityErrStrobe |=> rawStatus_ff[4])
    else $error("parity flag not set");
  AST_FRAME_SET: assert property (frameErrStrobe |=> rawStatus_ff[3])
    else $error("framing flag not set");
  AST_CLEAR_ZERO: assert property (irqClearWr && !irqClearData[3] && rawStatus_ff[3]
    |=> rawStatus_ff[3])
    else $error("framing flag lost on zero clear bit");
  AST_CLEAR_ONE: assert property (irqClearWr && irqClearData[4] && !parityErrStrobe
    |=> !rawStatus_ff[4])
    else $error("parity flag kept after clear");
  AST_RX_DMA_CLR: assert property (rxDmaReqClear |=> !rxDmaSingleReq_ff && !rxDmaBurstReq_ff)
    else $error("rx dma request kept after clear");
  AST_TX_DMA_CLR: assert property (txDmaReqClear |=> !txDmaSingleReq_ff && !txDmaBurstReq_ff)
    else $error("tx dma request kept after clear");
  AST_BURST_SINGLE: assert property (rxDmaBurstReq_ff |-> rxDmaSingleReq_ff)
    else $error("rx burst without single request");
  AST_DMA_STOP: assert property ($past(dmaStopOnRxError) && (|rawStatus_ff[6:3])
    |-> !rxDmaSingleReq_ff && !rxDmaBurstReq_ff)
    else $error("rx dma request during receive error");
  AST_RTS_OFF: assert property (!rxFlowCtrlEn |=> !requestToSend_n_ff)
    else $error("rts inactive with rx flow control off");
  COV_BURST: cover property (rxDmaBurstReq_ff && requestToSend_n_ff);
  COV_IRQ: cover property ($rose(serialPortIrq_ff));
  COV_TX_BURST: cover property ($fell(txDmaBurstReq_ff));
endmodule
`default_nettype wire

// ==== uidfc_shifter_model.sv ====
// transmit shifter model: loads a character and shifts it out
// assumes txStartOk_ff from uidfc_top; hold stalls new starts
`timescale 1ns/100ps
`default_nettype none
module uidfc_shifter_model #(
  parameter int BITS = 10
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hold,
  input wire logic txStartOk_ff,
  output logic txLoad,
  output logic txMsbDone,
  output int loads
);
  int cnt;
  always @(posedge clk) begin
    txLoad <= 1'b0;
    txMsbDone <= 1'b0;
    if (!nrst) begin
      cnt <= 0;
      loads <= 0;
    end else if (cnt != 0) begin
      // a started character always finishes
      cnt <= cnt - 1;
      if (cnt == 2) begin
        txMsbDone <= 1'b1;
      end
    end else if (txStartOk_ff && !txLoad && !hold) begin
      txLoad <= 1'b1;
      cnt <= BITS;
      loads <= loads + 1;
    end
  end
endmodule
`default_nettype wire

// ==== uidfc_top_tb.sv ====
// self-checking bench for the serial port irq, dma and flow control top
// assumes uidfc_top, uidfc_shifter_model and uidfc_top_sva compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module uidfc_top_tb;
  logic clk, nrst, fifoEnable, twoStopBitsSel, oversampleTickX16, stopBitStrobe, stopBitIsSecond, rxBreakBit;
  logic rxParityBit, rxFrameBit, parityErrStrobe, frameErrStrobe, rxReadReq, rxReadValid_ff, rxFifoNotEmpty;
  logic txWrValid, txWrReady, txLoad, txMsbDone, txStartOk_ff, irqClearWr, serialPortIrq_ff, rxDmaEn, txDmaEn;
  logic dmaStopOnRxError, rxDmaReqClear, txDmaReqClear, rxDmaSingleReq_ff, rxDmaBurstReq_ff, txDmaSingleReq_ff;
  logic txDmaBurstReq_ff, txFlowCtrlEn, rxFlowCtrlEn, clearToSend_n, requestToSend_n_ff, irEncodePulse;
  logic infraredRxIn_n, infraredTxOut_ff, irRxPulse_ff, hold;
  logic [7:0] rxCharData, txWrData, txChar_ff;
  logic [11:0] rxReadData_ff;
  logic [6:0] irqMask, irqClearData, rawStatus_ff, maskedStatus_ff;
  logic [2:0] rxWatermarkSel, txWatermarkSel;
  int fail_count, checks, loads, n;
  uidfc_top uut (.clk, .nrst, .fifoEnable, .twoStopBitsSel, .oversampleTickX16, .stopBitStrobe, .stopBitIsSecond,
    .rxCharData, .rxBreakBit, .rxParityBit, .rxFrameBit, .parityErrStrobe, .frameErrStrobe, .rxReadReq,
    .rxReadValid_ff, .rxReadData_ff, .rxFifoNotEmpty, .txWrValid, .txWrData, .txWrReady, .txLoad, .txMsbDone,
    .txStartOk_ff, .txChar_ff, .irqMask, .irqClearWr, .irqClearData, .rawStatus_ff, .maskedStatus_ff,
    .serialPortIrq_ff, .rxDmaEn, .txDmaEn, .dmaStopOnRxError, .rxWatermarkSel, .txWatermarkSel, .rxDmaReqClear,
    .txDmaReqClear, .rxDmaSingleReq_ff, .rxDmaBurstReq_ff, .txDmaSingleReq_ff, .txDmaBurstReq_ff, .txFlowCtrlEn,
    .rxFlowCtrlEn, .clearToSend_n, .requestToSend_n_ff, .irEncodePulse, .infraredRxIn_n, .infraredTxOut_ff,
    .irRxPulse_ff);
  uidfc_shifter_model #(.BITS(10)) peer (.clk, .nrst, .hold, .txStartOk_ff, .txLoad, .txMsbDone, .loads);
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task stopBit(input logic [7:0] d, input logic sec);
    rxCharData = d;
    stopBitIsSecond = sec;
    stopBitStrobe = 1;
    cyc(1);
    stopBitStrobe = 0;
    cyc(2);
  endtask
  task rd(input logic [7:0] e);
    rxReadReq = 1;
    cyc(1);
    rxReadReq = 0;
    `CHK("rdata", e, rxReadData_ff[7:0])
    `CHK("rvalid", 1'b1, rxReadValid_ff)
    cyc(2);
  endtask
  task clr(input logic [6:0] m);
    irqClearData = m;
    irqClearWr = 1;
    cyc(1);
    irqClearWr = 0;
    cyc(1);
  endtask
  task fill(output int k);
    k = 0;
    for (int i = 0; i < 40; i++) begin
      if (txWrReady === 1'b1) begin
        txWrData = k[7:0];
        txWrValid = 1;
        cyc(1);
        txWrValid = 0;
        cyc(2);
        k++;
      end else cyc(1);
      if (k == 4) begin
        txDmaReqClear = 1;
        cyc(1);
        txDmaReqClear = 0;
        `CHK("txClr", 1'b0, txDmaSingleReq_ff)
      end
      if (k == 7) `CHK("txBurst7", 1'b1, txDmaBurstReq_ff)
      if (k == 8) `CHK("txBurst8", 1'b0, txDmaBurstReq_ff)
    end
  endtask
  task results();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task t_flags();
    twoStopBitsSel = 1;
    stopBit(8'hA5, 0);
    `CHK("rxEarly", 1'b0, rawStatus_ff[0])
    stopBit(8'hA5, 1);
    `CHK("rxIrq", 1'b1, rawStatus_ff[0])
    twoStopBitsSel = 0;
    parityErrStrobe = 1;
    frameErrStrobe = 1;
    cyc(1);
    parityErrStrobe = 0;
    frameErrStrobe = 0;
    cyc(2);
    `CHK("errFlags", 2'h3, rawStatus_ff[4:3])
    irqMask = 7'h00;
    cyc(2);
    `CHK("irqOff", 1'b0, serialPortIrq_ff)
    irqMask = 7'h08;
    cyc(2);
    `CHK("irqOn", 1'b1, serialPortIrq_ff)
    `CHK("masked", 7'h08, maskedStatus_ff)
    clr(7'h00);
    `CHK("clrZero", 7'h19, rawStatus_ff)
    clr(7'h7F);
    `CHK("clrAll", 7'h00, rawStatus_ff)
    irqMask = 7'h7F;
    rd(8'hA5);
    $display("t_flags done");
  endtask
  task t_rx();
    rxWatermarkSel = 3'h2;
    rxDmaEn = 1;
    rxBreakBit = 1;
    `CHK("rtsOff", 1'b0, requestToSend_n_ff)
    rxFlowCtrlEn = 1;
    for (int i = 0; i < 5; i++) stopBit(8'h10 + i, 0);
    rxBreakBit = 0;
    `CHK("rxBurst", 1'b1, rxDmaBurstReq_ff)
    `CHK("rxBoth", 1'b1, rxDmaSingleReq_ff)
    `CHK("rxAvail", 1'b1, rxFifoNotEmpty)
    `CHK("rtsHigh", 1'b1, requestToSend_n_ff)
    `CHK("overrun", 1'b1, rawStatus_ff[6])
    `CHK("break", 1'b1, rawStatus_ff[5])
    dmaStopOnRxError = 1;
    cyc(2);
    `CHK("dmaStop", 1'b0, rxDmaSingleReq_ff)
    dmaStopOnRxError = 0;
    rxDmaReqClear = 1;
    cyc(1);
    rxDmaReqClear = 0;
    `CHK("rxClr", 1'b0, rxDmaSingleReq_ff)
    rd(8'h10);
    `CHK("rxFields", 4'hC, rxReadData_ff[11:8])
    `CHK("oeRead", 1'b0, rawStatus_ff[6])
    rd(8'h11);
    `CHK("rtsBack", 1'b0, requestToSend_n_ff)
    `CHK("singleOnly", 2'h2, {rxDmaSingleReq_ff, rxDmaBurstReq_ff})
    rd(8'h12);
    rd(8'h13);
    `CHK("rxEmpty", 1'b0, rxDmaSingleReq_ff)
    `CHK("rxNone", 1'b0, rxFifoNotEmpty)
    clr(7'h7F);
    $display("t_rx done");
  endtask
  task t_timeout();
    stopBit(8'h55, 0);
    oversampleTickX16 = 1;
    cyc(500);
    `CHK("rtEarly", 1'b0, rawStatus_ff[2])
    cyc(20);
    `CHK("rtLate", 1'b1, rawStatus_ff[2])
    oversampleTickX16 = 0;
    rd(8'h55);
    clr(7'h7F);
    $display("t_timeout done");
  endtask
  task t_tx();
    txDmaEn = 1;
    txWatermarkSel = 3'h1;
    txFlowCtrlEn = 1;
    hold = 0;
    fill(n);
    `CHK("txDepth", 32, n)
    `CHK("txFull", 1'b0, txDmaSingleReq_ff)
    `CHK("ctsBlock", 0, loads)
    clearToSend_n = 0;
    cyc(60);
    clearToSend_n = 1;
    n = loads;
    cyc(40);
    `CHK("ctsFinish", 1'b1, (loads - n) < 2)
    n = loads;
    cyc(40);
    `CHK("ctsStop", n, loads)
    `CHK("txHead", loads[7:0], txChar_ff)
    clearToSend_n = 0;
    for (int i = 0; i < 800 && rawStatus_ff[1] !== 1'b1; i++) cyc(1);
    `CHK("txAll", 32, loads)
    `CHK("txIrq", 1'b1, rawStatus_ff[1])
    `CHK("txFree", 2'h3, {txDmaSingleReq_ff, txDmaBurstReq_ff})
    hold = 1;
    fifoEnable = 0;
    clr(7'h7F);
    fill(n);
    `CHK("holdReg", 1, n)
    $display("t_tx done");
  endtask
  task t_ir();
    irEncodePulse = 1;
    infraredRxIn_n = 0;
    cyc(6);
    `CHK("irHigh", 1'b1, infraredTxOut_ff)
    `CHK("irRxHigh", 1'b1, irRxPulse_ff)
    irEncodePulse = 0;
    infraredRxIn_n = 1;
    cyc(6);
    `CHK("irLow", 1'b0, infraredTxOut_ff)
    `CHK("irRxLow", 1'b0, irRxPulse_ff)
    $display("t_ir done");
  endtask
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  initial begin
    #80000;
    fail_count++;
    results();
  end
  initial begin
    {nrst, twoStopBitsSel, oversampleTickX16, stopBitStrobe, stopBitIsSecond, rxBreakBit, rxParityBit} = '0;
    {rxFrameBit, parityErrStrobe, frameErrStrobe, rxReadReq, txWrValid, irqClearWr, rxDmaEn, txDmaEn} = '0;
    {dmaStopOnRxError, rxDmaReqClear, txDmaReqClear, txFlowCtrlEn, rxFlowCtrlEn, irEncodePulse} = '0;
    {rxCharData, txWrData, irqClearData, rxWatermarkSel, txWatermarkSel} = '0;
    {fifoEnable, clearToSend_n, infraredRxIn_n, hold} = 4'hF;
    irqMask = 7'h7F;
    cyc(3);
    nrst = 1;
    cyc(2);
    t_flags();
    t_rx();
    t_timeout();
    t_tx();
    t_ir();
    results();
  end
endmodule
bind uidfc_top uidfc_top_sva chk (.clk, .nrst, .twoStopBitsSel, .stopBitStrobe, .stopBitIsSecond, .parityErrStrobe,
  .frameErrStrobe, .irqMask, .irqClearWr, .irqClearData, .rawStatus_ff, .maskedStatus_ff, .serialPortIrq_ff,
  .dmaStopOnRxError, .rxDmaReqClear, .txDmaReqClear, .rxDmaSingleReq_ff, .rxDmaBurstReq_ff, .txDmaSingleReq_ff,
  .txDmaBurstReq_ff, .rxFlowCtrlEn, .requestToSend_n_ff);
`default_nettype wire
